// ===== include/otr_pkg.sv
package otr_pkg;

    // ******************************************************
    // Register map
    // ******************************************************
    localparam logic [7:0] OTR_CTRL_OFS   = 8'h00;
    localparam logic [7:0] OTR_STATUS_OFS = 8'h04;
    localparam logic [7:0] OTR_DATA_OFS   = 8'h08;

    // CTRL fields
    localparam int OTR_CTRL_SELECT_BIT = 0;
    localparam int OTR_CTRL_FREADY_BIT = 1;
    localparam int OTR_CTRL_INREQ_BIT  = 2;

    // STATUS fields
    localparam int OTR_ST_BACKWARD_BIT = 0;
    localparam int OTR_ST_SEEK_BIT     = 1;
    localparam int OTR_ST_RESUME_BIT   = 2;
    localparam int OTR_ST_INRDY_BIT    = 3;
    localparam int OTR_ST_LOCKOUT_BIT  = 4;
    localparam int OTR_ST_PHASE_BIT    = 5;
    localparam int OTR_ST_OVERRUN_BIT  = 6;
    localparam int OTR_ST_HREADY_BIT   = 8;
    localparam int OTR_ST_HFAULT_BIT   = 9;
    localparam int OTR_ST_HBUSY_BIT    = 10;
    localparam int OTR_ST_HLOAD_BIT    = 11;

    // DATA fields
    localparam int OTR_DATA_VALID_BIT = 31;

    // ******************************************************
    // Reset values and sizes
    // ******************************************************
    localparam logic       OTR_PHASE_ODD   = 1'b0;
    localparam logic       OTR_SELECT_RST  = 1'b0;
    localparam logic [31:0] OTR_HRDATA_RST = 32'h0000_0000;
    localparam int          OTR_FRAME_W    = 6;
    localparam int          OTR_FIFO_DEPTH = 8;

    // ******************************************************
    // Carriers
    // ******************************************************
    typedef struct packed {
        logic                   ready;
        logic                   fault;
        logic                   busy;
        logic                   load_point;
        logic                   sprocket;
        logic                   end_of_record;
        logic [OTR_FRAME_W-1:0] frame;
    } otr_tape_in_t;

    typedef struct packed {
        logic reverse;
        logic read_en;
        logic stop_on_file_mark;
    } otr_tape_out_t;

endpackage

// ===== src/otr_ctrl.sv
`timescale 1ns/10ps

// ******************************************************
// Word FIFO
// ******************************************************
module otr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = otr_pkg::OTR_FIFO_DEPTH
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power of two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
        $error("otr_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_r != rd_ptr_r;
    assign out_data  = mem[rd_ptr_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
            end
        end
    end
endmodule

module otr_ctrl #(
    parameter int FRAME_W = otr_pkg::OTR_FRAME_W,
    parameter int DEPTH   = otr_pkg::OTR_FIFO_DEPTH
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire otr_pkg::otr_tape_in_t tape_in,
    output otr_pkg::otr_tape_out_t    tape_out
);
    localparam int WORD_W = 2 * FRAME_W;

    if (FRAME_W != otr_pkg::OTR_FRAME_W || WORD_W > 31) begin : g_bad_frame
        $error("otr_ctrl: frame width must match the tape carrier");
    end

    function automatic logic is_reg(input logic [31:0] a, input logic [7:0] ofs);
        is_reg = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
    endfunction

    // ******************************************************
    // Handler input synchronisers
    // ******************************************************
    otr_pkg::otr_tape_in_t tin_s1_r;
    otr_pkg::otr_tape_in_t tin_s2_r;
    logic                  sprk_d_r;
    logic                  eor_d_r;
    logic                  sprk_ev;
    logic                  eor_ev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tin_s1_r <= '0;
            tin_s2_r <= '0;
            sprk_d_r <= 1'b0;
            eor_d_r  <= 1'b0;
        end else begin
            tin_s1_r <= tape_in;
            tin_s2_r <= tin_s1_r;
            sprk_d_r <= tin_s2_r.sprocket;
            eor_d_r  <= tin_s2_r.end_of_record;
        end
    end

    assign sprk_ev = tin_s2_r.sprocket && !sprk_d_r;
    assign eor_ev  = tin_s2_r.end_of_record && !eor_d_r;

    // ******************************************************
    // AHB-Lite slave
    // ******************************************************
    logic        wr_pend_r;
    logic        wr_ctrl;
    logic        rd_take;
    logic        pop_data;
    logic        select_r;
    logic        fready_r;
    logic        inreq_r;
    logic [31:0] status_word;
    logic        fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic [WORD_W-1:0] data_shown;

    assign rd_take  = hsel && hready && htrans[1] && !hwrite;
    assign pop_data = rd_take && is_reg(haddr, otr_pkg::OTR_DATA_OFS) && fifo_out_valid;
    assign wr_ctrl  = wr_pend_r;
    // An empty buffer shows zeros rather than a stale slot
    assign data_shown = fifo_out_valid ? fifo_out_data : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            // Zero wait state slave, always OKAY
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
        end else if (hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite && is_reg(haddr, otr_pkg::OTR_CTRL_OFS);
        end
    end

    // Read data is registered at the address phase so it stands for the whole data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= otr_pkg::OTR_HRDATA_RST;
        end else if (rd_take) begin
            if (is_reg(haddr, otr_pkg::OTR_CTRL_OFS)) begin
                hrdata <= {31'h0000_0000, select_r};
            end else if (is_reg(haddr, otr_pkg::OTR_STATUS_OFS)) begin
                hrdata <= status_word;
            end else if (is_reg(haddr, otr_pkg::OTR_DATA_OFS)) begin
                hrdata <= {fifo_out_valid, (31-WORD_W)'(0), data_shown};
            end else begin
                hrdata <= otr_pkg::OTR_HRDATA_RST;
            end
        end
    end

    // Select is a level; function ready and input request are one-cycle strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            select_r <= otr_pkg::OTR_SELECT_RST;
            fready_r <= 1'b0;
            inreq_r  <= 1'b0;
        end else begin
            fready_r <= wr_ctrl && hwdata[otr_pkg::OTR_CTRL_FREADY_BIT];
            inreq_r  <= wr_ctrl && hwdata[otr_pkg::OTR_CTRL_INREQ_BIT];
            if (wr_ctrl) begin
                select_r <= hwdata[otr_pkg::OTR_CTRL_SELECT_BIT];
            end
        end
    end

    // ******************************************************
    // Operation control
    // ******************************************************
    logic backward_drive_r;
    logic seek_pending_r;
    logic op_start;
    logic pseudo_eor;

    assign op_start = select_r && fready_r && tin_s2_r.ready && !tin_s2_r.fault
                   && !tin_s2_r.busy && !tin_s2_r.load_point
                   && !backward_drive_r && !seek_pending_r;
    assign pseudo_eor = seek_pending_r && eor_ev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            backward_drive_r <= 1'b0;
        end else if (op_start) begin
            backward_drive_r <= 1'b1;
        end else if (eor_ev) begin
            backward_drive_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seek_pending_r <= 1'b0;
        end else if (op_start) begin
            seek_pending_r <= 1'b1;
        end else if (inreq_r || pseudo_eor) begin
            seek_pending_r <= 1'b0;
        end
    end

    // Handler controls come straight from flops, refreshed from the drive flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tape_out <= '0;
        end else begin
            tape_out.reverse           <= backward_drive_r && !eor_ev;
            tape_out.read_en           <= backward_drive_r && !eor_ev;
            tape_out.stop_on_file_mark <= seek_pending_r && !inreq_r && !pseudo_eor;
        end
    end

    // ******************************************************
    // Timing loop and sequencer
    // ******************************************************
    // A frame is held until the next sprocket proves it is not the check frame;
    // the frame still pending at end of record is the check character.
    // The lockout makes the next sprocket skip it instead of moving it on.
    logic [FRAME_W-1:0] capture_r;
    logic               capture_vld_r;
    logic               check_frame_lockout_r;
    logic               phase_r;
    logic [WORD_W-1:0]  word_r;
    logic               word_handoff_r;
    logic               overrun_r;
    logic               word_done_r;
    logic [WORD_W-1:0]  handoff_word_r;
    logic               loop_go;
    logic               fifo_in_ready;

    assign loop_go = sprk_ev && capture_vld_r && !check_frame_lockout_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_r     <= '0;
            capture_vld_r <= 1'b0;
        end else if (sprk_ev) begin
            capture_r     <= tin_s2_r.frame;
            capture_vld_r <= 1'b1;
        end else if (op_start) begin
            capture_vld_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            check_frame_lockout_r <= 1'b0;
        end else if (eor_ev) begin
            check_frame_lockout_r <= 1'b1;
        end else if (op_start || sprk_ev) begin
            // Released by the sprocket that skips the check frame
            check_frame_lockout_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= otr_pkg::OTR_PHASE_ODD;
        end else if (op_start || eor_ev) begin
            phase_r <= otr_pkg::OTR_PHASE_ODD;
        end else if (loop_go) begin
            phase_r <= !phase_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_r <= '0;
        end else if (loop_go && phase_r == otr_pkg::OTR_PHASE_ODD) begin
            word_r[WORD_W-1:FRAME_W] <= capture_r;
        end else if (loop_go) begin
            word_r[FRAME_W-1:0] <= capture_r;
        end
    end

    // A finished word waits one cycle so both halves are settled in the assembly register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_done_r <= 1'b0;
        end else begin
            word_done_r <= loop_go && phase_r != otr_pkg::OTR_PHASE_ODD && !backward_drive_r;
        end
    end

    // Handoff keeps its own copy until the FIFO takes it, so later frames cannot corrupt it;
    // a word finished meanwhile replaces the waiting one and is flagged as an overrun
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_handoff_r <= 1'b0;
            handoff_word_r <= '0;
            overrun_r      <= 1'b0;
        end else begin
            if (op_start) begin
                overrun_r <= 1'b0;
            end
            if (word_done_r) begin
                word_handoff_r <= 1'b1;
                handoff_word_r <= word_r;
                if (word_handoff_r && !fifo_in_ready) begin
                    overrun_r <= 1'b1;
                end
            end else if (fifo_in_ready) begin
                word_handoff_r <= 1'b0;
            end
        end
    end

    // ******************************************************
    // Word buffer toward the bus
    // ******************************************************
    logic [WORD_W-1:0] fifo_in_data;

    assign fifo_in_data = handoff_word_r;

    otr_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (word_handoff_r),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop_data),
        .out_data  (fifo_out_data)
    );

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[otr_pkg::OTR_ST_BACKWARD_BIT] = backward_drive_r;
        status_word[otr_pkg::OTR_ST_SEEK_BIT]     = seek_pending_r;
        status_word[otr_pkg::OTR_ST_RESUME_BIT]   = seek_pending_r;
        status_word[otr_pkg::OTR_ST_INRDY_BIT]    = fifo_out_valid;
        status_word[otr_pkg::OTR_ST_LOCKOUT_BIT]  = check_frame_lockout_r;
        status_word[otr_pkg::OTR_ST_PHASE_BIT]    = phase_r;
        status_word[otr_pkg::OTR_ST_OVERRUN_BIT]  = overrun_r;
        status_word[otr_pkg::OTR_ST_HREADY_BIT]   = tin_s2_r.ready;
        status_word[otr_pkg::OTR_ST_HFAULT_BIT]   = tin_s2_r.fault;
        status_word[otr_pkg::OTR_ST_HBUSY_BIT]    = tin_s2_r.busy;
        status_word[otr_pkg::OTR_ST_HLOAD_BIT]    = tin_s2_r.load_point;
    end
endmodule

// ===== test/otr_ctrl_assertions.sv
`timescale 1ns/10ps

// ******************************************************
// Port checks
// ******************************************************
module otr_ctrl_assertions (
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire otr_pkg::otr_tape_in_t  tape_in,
    input wire otr_pkg::otr_tape_out_t tape_out
);
    logic [3:0] eor_age_r;

    // Saturates, so a stale end of record never excuses a late drop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eor_age_r <= 4'hF;
        end else if (tape_in.end_of_record) begin
            eor_age_r <= 4'h0;
        end else if (eor_age_r != 4'hF) begin
            eor_age_r <= eor_age_r + 4'h1;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_no_wait: assert property ($past(hresetn) |-> hreadyout)
        else $error("wait state inserted");
    a_rev_read: assert property (tape_out.reverse == tape_out.read_en)
        else $error("reverse and read enable differ");
    a_seek_start: assert property ($rose(tape_out.stop_on_file_mark) |-> $rose(tape_out.reverse))
        else $error("seek pending set without backward start");
    a_start_gate: assert property ($rose(tape_out.reverse) |-> tape_in.ready && !tape_in.fault && !tape_in.load_point)
        else $error("backward start with handler not ready");
    a_start_idle: assert property ($rose(tape_out.reverse) |-> !tape_in.busy)
        else $error("backward start with handler busy");
    a_rev_held: assert property ($fell(tape_out.reverse) |-> eor_age_r < 4'h8)
        else $error("reverse dropped without end of record");
    a_eor_clears: assert property ($fell(tape_out.reverse) |-> !tape_out.stop_on_file_mark)
        else $error("stop on file mark left after end of record");
endmodule

// ===== test/otr_tape_model.sv
`timescale 1ns/10ps

// ******************************************************
// Tape handler model
// ******************************************************
module otr_tape_model (
    input wire otr_pkg::otr_tape_out_t tape_out,
    input wire logic                   hclk,
    output otr_pkg::otr_tape_in_t      tape_in
);
    int gap = 0;

    initial begin
        tape_in = '0;
        tape_in.ready = 1'b1;
    end

    task automatic set_status(input logic rdy, input logic flt, input logic ld);
        tape_in.ready <= rdy;
        tape_in.fault <= flt;
        tape_in.load_point <= ld;
    endtask

    task automatic send_frame(input logic [5:0] f);
        @(posedge hclk);
        tape_in.frame <= f;
        repeat (gap + 1) @(posedge hclk);
        tape_in.sprocket <= 1'b1;
        repeat (3) @(posedge hclk);
        tape_in.sprocket <= 1'b0;
        repeat (2) @(posedge hclk);
        // Lines are not held after the pulse, so show a changed value
        tape_in.frame <= ~f;
    endtask

    task automatic end_record();
        @(posedge hclk);
        tape_in.end_of_record <= 1'b1;
        repeat (3) @(posedge hclk);
        tape_in.end_of_record <= 1'b0;
    endtask

    // Backward motion runs one record, then busy lingers as a real drive
    initial begin
        forever begin
            @(posedge hclk iff tape_out.reverse);
            tape_in.busy <= 1'b1;
            repeat (3) send_frame(6'h2A);
            end_record();
            @(posedge hclk iff !tape_out.reverse);
            repeat (12) @(posedge hclk);
            tape_in.busy <= 1'b0;
        end
    end
endmodule

// ===== test/tb_otr_ctrl.sv
`timescale 1ns/10ps

// ******************************************************
// Bench
// ******************************************************
module tb_otr_ctrl;
    logic                   hclk = 1'b0;
    logic                   hresetn = 1'b0;
    logic                   hsel = 1'b0;
    logic [31:0]            haddr = 32'h0;
    logic [1:0]             htrans = 2'h0;
    logic                   hwrite = 1'b0;
    logic [31:0]            hwdata = 32'h0;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
    otr_pkg::otr_tape_in_t  tape_in;
    otr_pkg::otr_tape_out_t tape_out;
    int                     miscompares = 0;
    int                     n_checks = 0;
    int                     cycles = 0;
    int                     seed = 82624;
    logic [31:0]            rd;
    logic [11:0]            w;
    logic [11:0]            words[$];

    always #25 hclk = ~hclk;

    otr_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tape_in(tape_in), .tape_out(tape_out));
    otr_tape_model handler (.hclk(hclk), .tape_out(tape_out), .tape_in(tape_in));

    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
        bus(1'b0, otr_pkg::OTR_STATUS_OFS, 32'h0);
        check("status", exp & mask, rd & mask);
    endtask

    task automatic wait_rev(input logic v);
        int n = 0;
        while (tape_out.reverse !== v && n < 400) begin
            @(posedge hclk);
            n++;
        end
        check("reverse", {31'h0, v}, {31'h0, tape_out.reverse});
    endtask

    task automatic wait_idle();
        int n = 0;
        do begin
            bus(1'b0, otr_pkg::OTR_STATUS_OFS, 32'h0);
            n++;
        end while (rd[10] !== 1'b0 && n < 60);
        check("busy", 32'h0, rd & 32'h400);
    endtask

    task automatic read_word(input logic [31:0] exp);
        repeat (6) @(posedge hclk);
        bus(1'b0, otr_pkg::OTR_DATA_OFS, 32'h0);
        check("data", exp, rd & 32'h8000_0FFF);
    endtask

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        stat(32'h17F, 32'h100);
        bus(1'b1, otr_pkg::OTR_STATUS_OFS, 32'hFFFF_FFFF);
        bus(1'b0, 8'h0C, 32'h0);
        check("unmapped", 32'h0, rd);
        for (int i = 0; i < 3; i++) begin
            handler.set_status(i != 0, i == 1, i == 2);
            repeat (4) @(posedge hclk);
            bus(1'b1, otr_pkg::OTR_CTRL_OFS, 32'h3);
            repeat (6) @(posedge hclk);
            stat(32'h7, 32'h0);
        end
        handler.set_status(1'b1, 1'b0, 1'b0);
        // Slow handler so the request lands mid-motion
        handler.gap = 8;
        bus(1'b1, otr_pkg::OTR_CTRL_OFS, 32'h3);
        repeat (3) @(posedge hclk);
        stat(32'h7, 32'h7);
        check("read_en", 32'h1, {31'h0, tape_out.read_en});
        bus(1'b1, otr_pkg::OTR_CTRL_OFS, 32'h5);
        repeat (3) @(posedge hclk);
        stat(32'h7, 32'h1);
        wait_rev(1'b0);
        stat(32'hF, 32'h0);
        bus(1'b1, otr_pkg::OTR_CTRL_OFS, 32'h3);
        repeat (4) @(posedge hclk);
        stat(32'h1, 32'h0);
        wait_idle();
        handler.send_frame(6'h15);
        handler.send_frame(6'h2A);
        repeat (4) @(posedge hclk);
        stat(32'h20, 32'h20);
        bus(1'b1, otr_pkg::OTR_CTRL_OFS, 32'h3);
        repeat (3) @(posedge hclk);
        stat(32'h27, 32'h7);
        check("file mark stop", 32'h1, {31'h0, tape_out.stop_on_file_mark});
        wait_rev(1'b0);
        stat(32'h7, 32'h0);
        wait_idle();
        // Ten words into an eight word buffer: the ninth waits in the handoff
        // and is replaced by the tenth, which raises the overrun flag
        handler.gap = 2;
        for (int i = 0; i < 10; i++) begin
            w = 12'($random(seed));
            words.push_back(w);
            handler.send_frame(w[11:6]);
            handler.send_frame(w[5:0]);
        end
        handler.send_frame(6'h3F);
        handler.end_record();
        repeat (6) @(posedge hclk);
        stat(32'h48, 32'h48);
        for (int i = 0; i < 8; i++) begin
            read_word({1'b1, 19'h0, words[i]});
        end
        read_word({1'b1, 19'h0, words[9]});
        w = 12'($random(seed));
        handler.send_frame(w[11:6]);
        handler.send_frame(w[5:0]);
        handler.send_frame(6'h3F);
        handler.end_record();
        read_word({1'b1, 19'h0, w});
        read_word(32'h0);
        end_of_test();
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
endmodule

bind otr_ctrl otr_ctrl_assertions chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .tape_in(tape_in), .tape_out(tape_out));
